// ==== verilog/tbic_timer.sv ====
// tbic_timer: timer time base with two input-capture channels, AXI4-Lite registers
// assumes one clock aclk (also the dead-time clock) and asynchronous capture pins
module tbic_timer #(
  parameter int NCH   = 2,
  parameter int CW    = 32,
  parameter int PSC_W = 16
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [tbic_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [tbic_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  input  wire logic [NCH-1:0]               capture_pin,
  output logic                              update_event,
  output logic [NCH-1:0]                    capture_irq_req,
  output logic [NCH-1:0]                    capture_dma_req
);

  if (NCH != 2 || CW < 2 || CW > 32 || PSC_W < 1 || PSC_W > 16) begin : g_chk
    $error("tbic_timer: NCH must be 2, CW 2..32, PSC_W 1..16");
  end

  tbic_pkg::tbic_ctrl_s  ctrl_reg;
  tbic_pkg::tbic_ctrl_s  ctrl_wr;
  tbic_pkg::tbic_chcfg_s chcfg_reg [NCH];
  tbic_pkg::tbic_phase_e phase_reg, phase_next;
  logic [tbic_pkg::IE_W-1:0] ie_reg;
  logic [CW-1:0]    cnt_reg, cnt_next, arr_reg, arr_sh_reg, arr_sh_next, reinit_arr;
  logic [PSC_W-1:0] psc_reg, psc_act_reg, psc_cnt_reg, psc_cnt_next;
  logic [CW-1:0]    ccr_reg [NCH];
  logic [CW-1:0]    cap_shadow_reg [NCH];
  logic [NCH-1:0]   ccf_reg, cof_reg, cap_load_reg, irq_reg, dma_reg;
  logic [NCH-1:0]   sync1_reg, sync2_reg, sync3_reg, pin_q_reg, filt_reg, filt_prev_reg;
  logic [NCH-1:0]   edge_qualified_input, divided_capture_event, rise, fall, ccg;
  logic             upd_flag_reg, update_reg, wrap;
  logic [4:0]       dts_div_reg;
  logic             aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
  logic [5:0]       aw_addr_reg;
  logic [31:0]      w_data_reg, rdata_reg, wr_merged;
  logic [3:0]       w_strb_reg;
  logic [1:0]       bresp_reg, rresp_reg;
  logic [32:0]      rd_view, wr_view;

  // read view of the map: {hit, value}
  function automatic logic [32:0] reg_view(input logic [5:0] a);
    case (a)
      tbic_pkg::OFS_CTRL:       reg_view = {1'b1, 32'(ctrl_reg)};
      tbic_pkg::OFS_STATUS:     reg_view = {1'b1, 26'h0, phase_reg == tbic_pkg::PH_DOWN,
                                            cof_reg, ccf_reg, upd_flag_reg};
      tbic_pkg::OFS_EVENT:      reg_view = {1'b1, 32'h0};
      tbic_pkg::OFS_IRQ_DMA_EN: reg_view = {1'b1, 32'(ie_reg)};
      tbic_pkg::OFS_CH_CFG:     reg_view = {1'b1, 32'(chcfg_reg[0])};
      tbic_pkg::OFS_CH_CFG + tbic_pkg::CH_STRIDE: reg_view = {1'b1, 32'(chcfg_reg[1])};
      tbic_pkg::OFS_COUNT:      reg_view = {1'b1, 32'(cnt_reg)};
      tbic_pkg::OFS_DIVIDER:    reg_view = {1'b1, 32'(psc_reg)};
      tbic_pkg::OFS_RELOAD:     reg_view = {1'b1, 32'(arr_reg)};
      tbic_pkg::OFS_CAPTURE:    reg_view = {1'b1, 32'(ccr_reg[0])};
      tbic_pkg::OFS_CAPTURE + tbic_pkg::CH_STRIDE: reg_view = {1'b1, 32'(ccr_reg[1])};
      default:                  reg_view = {1'b0, 32'h0};
    endcase
  endfunction

  always_comb begin
    rd_view   = reg_view(araddr);
    wr_view   = reg_view(aw_addr_reg);
    wr_merged = tbic_pkg::wmerge(wr_view[31:0], w_data_reg, w_strb_reg);
    ctrl_wr   = tbic_pkg::tbic_ctrl_s'(wr_merged[tbic_pkg::CTRL_W-1:0]);
    if (ctrl_reg.alignment_select != 2'h0) begin
      ctrl_wr.dir = ctrl_reg.dir;
    end
  end

  // bus decode
  wire wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire rd_fire = arvalid & arready;
  wire wr_ctrl = wr_fire & (aw_addr_reg == tbic_pkg::OFS_CTRL);
  wire wr_stat = wr_fire & (aw_addr_reg == tbic_pkg::OFS_STATUS) & w_strb_reg[0];
  wire wr_evt  = wr_fire & (aw_addr_reg == tbic_pkg::OFS_EVENT) & w_strb_reg[0];
  wire wr_ie   = wr_fire & (aw_addr_reg == tbic_pkg::OFS_IRQ_DMA_EN);
  wire wr_cnt  = wr_fire & (aw_addr_reg == tbic_pkg::OFS_COUNT);
  wire wr_psc  = wr_fire & (aw_addr_reg == tbic_pkg::OFS_DIVIDER);
  wire wr_arr  = wr_fire & (aw_addr_reg == tbic_pkg::OFS_RELOAD);

  assign awready = ~aw_have_reg & ~bvalid_reg;
  assign wready  = ~w_have_reg & ~bvalid_reg;
  assign arready = ~rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= tbic_pkg::RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_view[32] ? tbic_pkg::RESP_OKAY : tbic_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= tbic_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_view[31:0];
      rresp_reg  <= rd_view[32] ? tbic_pkg::RESP_OKAY : tbic_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // time base
  wire centre     = ctrl_reg.alignment_select != 2'h0;
  wire down_mode  = ~centre & ctrl_reg.dir;
  wire trig_edge  = edge_qualified_input[ctrl_reg.trig_sel];
  wire slave_rst  = (ctrl_reg.slave_mode_select == tbic_pkg::SMS_RESET) & trig_edge;
  wire ug         = wr_evt & w_data_reg[tbic_pkg::EV_UG_BIT];
  wire reinit     = ug | slave_rst;
  // only internal clocking; slave codes other than off and reset stop the counter
  wire counting   = ctrl_reg.counter_enable &
                    ((ctrl_reg.slave_mode_select == tbic_pkg::SMS_OFF) |
                     (ctrl_reg.slave_mode_select == tbic_pkg::SMS_RESET));
  wire tick       = counting & (psc_cnt_reg == psc_act_reg);
  wire upd_evt    = (reinit | wrap) & ~ctrl_reg.update_disable;

  // on a reinit the down counter reloads what the shadow will hold afterwards
  assign reinit_arr  = (ctrl_reg.reload_buffer_enable & ctrl_reg.update_disable) ?
                       arr_sh_reg : arr_reg;
  assign arr_sh_next = (!ctrl_reg.reload_buffer_enable || upd_evt) ? arr_reg :
                       arr_sh_reg;
  assign psc_cnt_next = (reinit | upd_evt | tick) ? '0 :
                        counting ? psc_cnt_reg + 1'b1 : psc_cnt_reg;

  always_comb begin
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    wrap       = 1'b0;
    if (reinit) begin
      cnt_next   = down_mode ? reinit_arr : '0;
      phase_next = tbic_pkg::PH_UP;
    end else if (wr_cnt) begin
      cnt_next = wr_merged[CW-1:0];
    end else if (tick) begin
      if (!centre && !down_mode) begin
        wrap     = cnt_reg >= arr_sh_reg;
        cnt_next = wrap ? '0 : cnt_reg + 1'b1;
      end else if (!centre) begin
        wrap     = cnt_reg == '0;
        cnt_next = wrap ? arr_sh_reg : cnt_reg - 1'b1;
      end else begin
        case (phase_reg)
          tbic_pkg::PH_UP: begin
            wrap       = ({1'b0, cnt_reg} + (CW+1)'(1)) >= {1'b0, arr_sh_reg};
            cnt_next   = wrap ? arr_sh_reg : cnt_reg + 1'b1;
            phase_next = wrap ? tbic_pkg::PH_DOWN : tbic_pkg::PH_UP;
          end
          tbic_pkg::PH_DOWN: begin
            wrap       = cnt_reg <= CW'(1);
            cnt_next   = wrap ? '0 : cnt_reg - 1'b1;
            phase_next = wrap ? tbic_pkg::PH_UP : tbic_pkg::PH_DOWN;
          end
          default: phase_next = tbic_pkg::PH_UP;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= '0;
      ie_reg       <= '0;
      cnt_reg      <= '0;
      phase_reg    <= tbic_pkg::PH_UP;
      psc_reg      <= PSC_W'(tbic_pkg::DIVIDER_RST);
      psc_act_reg  <= PSC_W'(tbic_pkg::DIVIDER_RST);
      psc_cnt_reg  <= '0;
      arr_reg      <= CW'(tbic_pkg::RELOAD_RST);
      arr_sh_reg   <= CW'(tbic_pkg::RELOAD_RST);
      upd_flag_reg <= 1'b0;
      update_reg   <= 1'b0;
      dts_div_reg  <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_wr;
      if (wr_ie) ie_reg <= wr_merged[tbic_pkg::IE_W-1:0];
      if (wr_psc) psc_reg <= wr_merged[PSC_W-1:0];
      if (wr_arr) arr_reg <= wr_merged[CW-1:0];
      cnt_reg     <= cnt_next;
      phase_reg   <= phase_next;
      psc_cnt_reg <= psc_cnt_next;
      psc_act_reg <= upd_evt ? psc_reg : psc_act_reg;
      arr_sh_reg  <= arr_sh_next;
      // set wins over a software clear in the same cycle
      upd_flag_reg <= upd_evt | (upd_flag_reg &
                      ~(wr_stat & ~w_data_reg[tbic_pkg::ST_UPD_BIT]));
      update_reg  <= upd_evt;
      dts_div_reg <= dts_div_reg + 1'b1;
    end
  end
  assign update_event = update_reg;

  // capture channels
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    localparam int OTHER = NCH - 1 - n;
    localparam logic [5:0] CFG_OFS = tbic_pkg::OFS_CH_CFG + 6'(n * 4);
    localparam logic [5:0] CAP_OFS = tbic_pkg::OFS_CAPTURE + 6'(n * 4);
    tbic_pkg::tbic_chcfg_s cfg;
    logic [3:0] fcnt_reg;
    logic [2:0] cdiv_cnt_reg;
    assign cfg = chcfg_reg[n];
    wire [4:0] smask  = 5'((6'h01 << tbic_pkg::filt_shift(cfg.input_filter_select)) - 6'h01);
    wire       sample = (dts_div_reg & smask) == 5'h00;
    wire [3:0] flen   = tbic_pkg::filt_len(cfg.input_filter_select);
    wire       is_in  = (cfg.channel_direction_select == tbic_pkg::SEL_OWN) |
                        (cfg.channel_direction_select == tbic_pkg::SEL_OTHER);
    wire       src    = (cfg.channel_direction_select == tbic_pkg::SEL_OTHER) ? 1'b1 : 1'b0;
    wire       r_src  = src ? rise[OTHER] : rise[n];
    wire       f_src  = src ? fall[OTHER] : fall[n];
    wire [2:0] cdiv_top = 3'((4'h1 << cfg.capture_divider_field) - 4'h1);
    wire       cap_evt  = divided_capture_event[n] | ccg[n];
    wire       ccf_clr  = (wr_stat & ~w_data_reg[tbic_pkg::ST_CCF_LSB + n]) |
                          (rd_fire & (araddr == CAP_OFS));
    wire       cof_clr  = wr_stat & ~w_data_reg[tbic_pkg::ST_COF_LSB + n];

    assign rise[n] = filt_reg[n] & ~filt_prev_reg[n];
    assign fall[n] = ~filt_reg[n] & filt_prev_reg[n];
    assign edge_qualified_input[n] = is_in & (cfg.channel_edge_polarity ? f_src : r_src);
    assign divided_capture_event[n] = edge_qualified_input[n] & cfg.channel_enable &
                                      (cdiv_cnt_reg == cdiv_top);
    assign ccg[n] = wr_evt & w_data_reg[tbic_pkg::EV_CCG_LSB + n];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1_reg[n] <= 1'b0;
        sync2_reg[n] <= 1'b0;
        sync3_reg[n] <= 1'b0;
        pin_q_reg[n] <= 1'b0;
      end else begin
        sync1_reg[n] <= capture_pin[n];
        sync2_reg[n] <= sync1_reg[n];
        sync3_reg[n] <= sync2_reg[n];
        if (sync2_reg[n] == sync3_reg[n]) pin_q_reg[n] <= sync3_reg[n];
      end
    end

    // level moves only after flen agreeing samples in a row
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fcnt_reg         <= '0;
        filt_reg[n]      <= 1'b0;
        filt_prev_reg[n] <= 1'b0;
      end else begin
        filt_prev_reg[n] <= filt_reg[n];
        if (sample) begin
          if (pin_q_reg[n] == filt_reg[n]) begin
            fcnt_reg <= '0;
          end else if (fcnt_reg + 4'h1 >= flen) begin
            fcnt_reg    <= '0;
            filt_reg[n] <= pin_q_reg[n];
          end else begin
            fcnt_reg <= fcnt_reg + 4'h1;
          end
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        chcfg_reg[n]      <= '0;
        cdiv_cnt_reg      <= '0;
        cap_shadow_reg[n] <= '0;
        cap_load_reg[n]   <= 1'b0;
        ccr_reg[n]        <= '0;
        ccf_reg[n]        <= 1'b0;
        cof_reg[n]        <= 1'b0;
        irq_reg[n]        <= 1'b0;
        dma_reg[n]        <= 1'b0;
      end else begin
        if (wr_fire && aw_addr_reg == CFG_OFS) begin
          chcfg_reg[n] <= tbic_pkg::tbic_chcfg_s'(wr_merged[tbic_pkg::CHCFG_W-1:0]);
        end
        if (!cfg.channel_enable || divided_capture_event[n]) begin
          cdiv_cnt_reg <= '0;
        end else if (edge_qualified_input[n]) begin
          cdiv_cnt_reg <= cdiv_cnt_reg + 3'h1;
        end
        cap_load_reg[n] <= cap_evt;
        if (cap_evt) cap_shadow_reg[n] <= cnt_reg;
        if (cap_load_reg[n]) begin
          ccr_reg[n] <= cap_shadow_reg[n];
        end else if (wr_fire && aw_addr_reg == CAP_OFS && !is_in) begin
          ccr_reg[n] <= wr_merged[CW-1:0];
        end
        ccf_reg[n] <= cap_load_reg[n] | (ccf_reg[n] & ~ccf_clr);
        cof_reg[n] <= (cap_load_reg[n] & ccf_reg[n]) | (cof_reg[n] & ~cof_clr);
        irq_reg[n] <= cap_load_reg[n] & ie_reg[tbic_pkg::IE_CC_LSB + n];
        dma_reg[n] <= cap_load_reg[n] & ie_reg[tbic_pkg::IE_DMA_LSB + n];
      end
    end

    AST_CAP_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_evt |=> ##1 (ccf_reg[n] && ccr_reg[n] == $past(cnt_reg, 2)))
      else $error("capture did not load counter and flag");
    AST_OVERCAP: assert property (@(posedge aclk) disable iff (!aresetn)
      (cap_load_reg[n] && ccf_reg[n]) |=> cof_reg[n])
      else $error("overcapture flag missed");
  end

  assign capture_irq_req = irq_reg;
  assign capture_dma_req = dma_reg;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_PSC_WRAP: assert property (
    (tick && !reinit && !upd_evt) |=> psc_cnt_reg == '0)
    else $error("divider counter did not restart after tick");
  AST_PSC_LOAD: assert property (
    upd_evt |=> psc_act_reg == $past(psc_reg))
    else $error("pending divider not made active on update");
  AST_ARR_DIRECT: assert property (
    !ctrl_reg.reload_buffer_enable |=> arr_sh_reg == $past(arr_reg))
    else $error("unbuffered reload did not reach shadow");
  AST_UP_WRAP: assert property (
    (tick && !centre && !down_mode && cnt_reg >= arr_sh_reg && !reinit && !wr_cnt)
      |=> (cnt_reg == '0 && update_reg == !$past(ctrl_reg.update_disable)))
    else $error("up counter wrap wrong");
  AST_DOWN_WRAP: assert property (
    (tick && down_mode && cnt_reg == '0 && !reinit && !wr_cnt) |=> cnt_reg == $past(arr_sh_reg))
    else $error("down counter did not reload");
  AST_UPDATE_DISABLE: assert property (
    ctrl_reg.update_disable |=> !update_reg)
    else $error("update event while updates disabled");
  AST_UG_REINIT: assert property (
    (ug && !down_mode) |=> (cnt_reg == '0 && psc_cnt_reg == '0))
    else $error("software update did not reinitialise");
  AST_DIR_LOCK: assert property (
    (wr_ctrl && centre) |=> ctrl_reg.dir == $past(ctrl_reg.dir))
    else $error("direction changed in centre mode");
  AST_SLAVE_RST: assert property (
    (slave_rst && !down_mode) |=> cnt_reg == '0)
    else $error("trigger did not clear counter");

endmodule // tbic_timer

// ==== verilog/tbic_pkg.sv ====
// tbic_pkg: register map, field layout, carriers and helpers of the timer
// assumes a 32-bit AXI4-Lite register port with 6 address bits
package tbic_pkg;

  localparam int ADDR_W = 6;
  localparam int CTRL_W = 10;
  localparam int CHCFG_W = 10;

  localparam logic [5:0] OFS_CTRL       = 6'h00;
  localparam logic [5:0] OFS_STATUS     = 6'h04;
  localparam logic [5:0] OFS_EVENT      = 6'h08;
  localparam logic [5:0] OFS_IRQ_DMA_EN = 6'h0c;
  localparam logic [5:0] OFS_CH_CFG     = 6'h10;
  localparam logic [5:0] OFS_COUNT      = 6'h18;
  localparam logic [5:0] OFS_DIVIDER    = 6'h1c;
  localparam logic [5:0] OFS_RELOAD     = 6'h20;
  localparam logic [5:0] OFS_CAPTURE    = 6'h24;
  localparam logic [5:0] CH_STRIDE      = 6'h04;

  localparam int ST_UPD_BIT = 0;
  localparam int ST_CCF_LSB = 1;
  localparam int ST_COF_LSB = 3;
  localparam int ST_DIR_BIT = 5;
  localparam int EV_UG_BIT  = 0;
  localparam int EV_CCG_LSB = 1;
  localparam int IE_CC_LSB  = 0;
  localparam int IE_DMA_LSB = 2;
  localparam int IE_W       = 4;

  localparam logic [1:0]  SEL_OUTPUT  = 2'h0;
  localparam logic [1:0]  SEL_OWN     = 2'h1;
  localparam logic [1:0]  SEL_OTHER   = 2'h2;
  localparam logic [2:0]  SMS_OFF     = 3'h0;
  localparam logic [2:0]  SMS_RESET   = 3'h4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] DIVIDER_RST = 16'h0000;
  localparam logic [31:0] RELOAD_RST  = 32'hffffffff;

  typedef struct packed {
    logic       trig_sel;
    logic [2:0] slave_mode_select;
    logic       reload_buffer_enable;
    logic       update_disable;
    logic [1:0] alignment_select;
    logic       dir;
    logic       counter_enable;
  } tbic_ctrl_s;

  typedef struct packed {
    logic [3:0] input_filter_select;
    logic [1:0] capture_divider_field;
    logic       channel_enable;
    logic       channel_edge_polarity;
    logic [1:0] channel_direction_select;
  } tbic_chcfg_s;

  typedef enum logic [1:0] {PH_UP = 2'b01, PH_DOWN = 2'b10} tbic_phase_e;

  // log2 of the sample divider applied to the dead-time clock
  function automatic logic [2:0] filt_shift(input logic [3:0] code);
    case (code)
      4'h4, 4'h5:       filt_shift = 3'h1;
      4'h6, 4'h7:       filt_shift = 3'h2;
      4'h8, 4'h9:       filt_shift = 3'h3;
      4'ha, 4'hb, 4'hc: filt_shift = 3'h4;
      4'hd, 4'he, 4'hf: filt_shift = 3'h5;
      default:          filt_shift = 3'h0;
    endcase
  endfunction

  // samples that must agree before the filtered level moves
  function automatic logic [3:0] filt_len(input logic [3:0] code);
    case (code)
      4'h1:                   filt_len = 4'h2;
      4'h2:                   filt_len = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: filt_len = 4'h6;
      4'ha, 4'hd:             filt_len = 4'h5;
      4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: filt_len = 4'h8;
      default:                filt_len = 4'h1;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

endpackage

// ==== dv/tbic_pin_model.sv ====
// tbic_pin_model: external source driving the two capture pins
// assumes the timer synchronises and filters the pins itself
module tbic_pin_model (
  input  wire logic       aclk,
  output logic      [1:0] pin = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic pulse(input int ch, input int hi);
    pin[ch] <= 1'h1;
    repeat (hi) @(posedge aclk);
    pin[ch] <= 1'h0;
  endtask
endmodule // tbic_pin_model

// ==== dv/tb.sv ====
// tb: timer over AXI4-Lite, update gaps and captures checked against a model
// assumes the pin model drives the capture pins; bready and rready stay high
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, arvalid = '0;
  logic        awready, wready, bvalid, arready, rvalid, update_event;
  logic [5:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, c, arr, psc, n;
  logic [1:0]  bresp, rresp, rs, bs, pin, irq, dma;
  int          error_cnt = 0, check_count = 0, cyc = 0, upd_n = 0, irq_n = 0, h, p;
  tbic_timer dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready(1'h1), .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready(1'h1), .capture_pin(pin), .update_event, .capture_irq_req(irq),
    .capture_dma_req(dma));
  tbic_pin_model pins (.aclk, .pin);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (update_event === 1'h1) upd_n++;
    if (irq[0] === 1'h1 && dma[0] === 1'h1) irq_n++;
    if (++cyc == 20000) report_and_stop();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
  endtask
  // address and data offered together; each channel is let go at the edge that takes it
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_done = 1'h0;
    logic w_done  = 1'h0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'h1) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_done && wready === 1'h1) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    bs = bresp;
  endtask
  task automatic rd(input logic [5:0] a);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    c  = rdata;
    rs = rresp;
  endtask
  task automatic report_and_stop();
    if (cyc >= 20000) error_cnt++;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(39));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(6'h3c);
    chk(32'(rs), 32'(tbic_pkg::RESP_SLVERR));
    wr(6'h3c, 32'h0);
    chk(32'(bs), 32'(tbic_pkg::RESP_SLVERR));
    // every alignment code, code 0 with and without the direction bit and codes 1 to 3 without it, as the bit is held in centre mode; the first gaps are
    // skipped because a mode change leaves the counter mid-period
    for (int m = 0; m < 7; m++) begin
      arr = 32'h3 + $urandom % 8;
      psc = $urandom % 3;
      wr(tbic_pkg::OFS_RELOAD, arr);
      wr(tbic_pkg::OFS_DIVIDER, psc);
      wr(tbic_pkg::OFS_EVENT, 32'h1);
      wr(tbic_pkg::OFS_CTRL, 32'h1 | (m << 1));
      repeat (2) do @(posedge aclk); while (update_event !== 1'h1);
      for (n = 0; n == 0 || update_event !== 1'h1; n++) @(posedge aclk);
      chk(n, (psc + 1) * (m < 2 ? arr + 1 : arr));
    end
    // leave centre mode first: direction writes are ignored while it is selected
    wr(tbic_pkg::OFS_CTRL, 32'h10);
    wr(tbic_pkg::OFS_CTRL, 32'h12);
    wr(tbic_pkg::OFS_COUNT, 32'h3);
    upd_n = 0;
    wr(tbic_pkg::OFS_EVENT, 32'h1);
    rd(tbic_pkg::OFS_COUNT);
    chk(c, arr);
    chk(32'(upd_n), 32'h0);
    wr(tbic_pkg::OFS_COUNT, 32'h77);
    wr(tbic_pkg::OFS_CH_CFG, 32'h9);
    wr(tbic_pkg::OFS_IRQ_DMA_EN, 32'h5);
    wr(tbic_pkg::OFS_EVENT, 32'h2);
    pins.pulse(0, 4);
    repeat (20) @(posedge aclk);
    rd(tbic_pkg::OFS_STATUS);
    chk(c & 32'h1e, 32'ha);
    rd(tbic_pkg::OFS_CAPTURE);
    chk(c, 32'h77);
    rd(tbic_pkg::OFS_STATUS);
    chk(c & 32'h2, 32'h0);
    chk(32'(irq_n), 32'h2);
    // pwm input: channel 1 takes channel 0's pin on falling edges, rising edges reset
    h = 2 + $urandom % 6;
    p = h + 4 + $urandom % 8;
    wr(tbic_pkg::OFS_RELOAD, 32'hffff);
    wr(tbic_pkg::OFS_DIVIDER, 32'h0);
    wr(tbic_pkg::OFS_CH_CFG + tbic_pkg::CH_STRIDE, 32'he);
    wr(tbic_pkg::OFS_CTRL, 32'h101);
    wr(tbic_pkg::OFS_EVENT, 32'h1);
    repeat (2) begin
      pins.pulse(0, h);
      repeat (p - h) @(posedge aclk);
    end
    pins.pulse(0, h);
    repeat (20) @(posedge aclk);
    // counter restarts at 0 on each rising edge, one count per clock
    rd(tbic_pkg::OFS_CAPTURE);
    chk(c, 32'(p - 1));
    rd(tbic_pkg::OFS_CAPTURE + tbic_pkg::CH_STRIDE);
    chk(c, 32'(h - 1));
    report_and_stop();
  end
endmodule // tb
